// file: logic/rbss_pkg.sv
// Shared constants and types for the reset and boot strap select block
package rbss_pkg;

  localparam int CLK_MHZ          = 40;
  localparam int SLOW_TIMEOUT_NS  = 100000;
  localparam int SLOW_TIMEOUT_CYC = SLOW_TIMEOUT_NS * CLK_MHZ / 1000;
  localparam int SLOW_CNT_W       = 12;
  localparam int RADIO_GAP_NS     = 250;
  localparam int RADIO_GAP_CYC    = (RADIO_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int RADIO_CNT_W      = 8;

  localparam int ADR_W            = 4;
  localparam int DAT_W            = 32;
  localparam logic [ADR_W-1:0] ADR_STATUS  = 4'h0;
  localparam logic [ADR_W-1:0] ADR_CONTROL = 4'h4;
  localparam logic [ADR_W-1:0] ADR_STRAPS  = 4'h8;

  localparam int CTL_RADIO_LSB    = 0;
  localparam int CTL_LP_BIT       = 2;

  localparam int ST_FLASH_1V8     = 0;
  localparam int ST_DOWNLOAD      = 1;
  localparam int ST_RESERVED      = 2;
  localparam int ST_LOG           = 3;
  localparam int ST_SDIO_IN_RISE  = 4;
  localparam int ST_SDIO_OUT_RISE = 5;
  localparam int ST_SLOW_OK       = 6;
  localparam int ST_WIFI          = 7;
  localparam int ST_BT            = 8;
  localparam int ST_LOW_POWER     = 9;
  localparam int ST_NORMAL        = 10;

  localparam int STRAP_W          = 5;
  localparam int SP_FLASH         = 0;
  localparam int SP_BOOT_LO       = 1;
  localparam int SP_BOOT_HI       = 2;
  localparam int SP_SDIO_LO       = 3;
  localparam int SP_LOG           = 4;
  localparam logic [STRAP_W-1:0] STRAP_PU = 5'h1d;
  localparam logic [STRAP_W-1:0] STRAP_PD = 5'h02;

  localparam logic [1:0] BOOT_DOWNLOAD = 2'h0;
  localparam logic [1:0] BOOT_RESERVED = 2'h1;

  typedef enum logic [1:0] {
    RADIO_NONE = 2'b00,
    RADIO_WIFI = 2'b01,
    RADIO_BT   = 2'b10
  } rbss_radio_type;

  typedef enum logic [1:0] {
    PH_HOLD   = 2'b00,
    PH_SAMPLE = 2'b01,
    PH_RUN    = 2'b10
  } rbss_phase_type;

endpackage

// file: logic/rbss_strap_capture.sv
// Strap latch and decode of flash supply, boot mode, log and SDIO timing
`timescale 1ns/10ps
`default_nettype none
module rbss_strap_capture
  import rbss_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               capture,
  input  wire logic [STRAP_W-1:0] strap_pins,
  output logic      [STRAP_W-1:0] raw,
  output logic                    flash_1v8,
  output logic                    download_boot,
  output logic                    normal_boot,
  output logic                    boot_reserved,
  output logic                    log_enable,
  output logic                    sdio_in_rising,
  output logic                    sdio_out_rising
);

  typedef struct packed {
    logic [STRAP_W-1:0] raw;
    logic               flash_1v8;
    logic               download;
    logic               normal;
    logic               reserved;
    logic               log_en;
    logic               in_rise;
    logic               out_rise;
  } rbss_strap_type;

  rbss_strap_type s_q;
  rbss_strap_type s_d;
  logic [1:0]     boot;
  logic [1:0]     sdio;

  always_comb
  begin
    s_d  = s_q;
    boot = {strap_pins[SP_BOOT_HI], strap_pins[SP_BOOT_LO]};
    sdio = {strap_pins[SP_LOG], strap_pins[SP_SDIO_LO]};
    // Latched once per boot; later pin changes are ignored
    if (capture)
    begin
      s_d.raw       = strap_pins;
      s_d.flash_1v8 = strap_pins[SP_FLASH];
      s_d.download  = (boot == BOOT_DOWNLOAD);
      s_d.reserved  = (boot == BOOT_RESERVED);
      s_d.normal    = boot[1];
      s_d.log_en    = strap_pins[SP_LOG];
      s_d.in_rise   = sdio[1];
      s_d.out_rise  = sdio[0];
    end
  end

  // Reset values equal what the internal pulls give on open pins
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      s_q <= '{raw: STRAP_PU, flash_1v8: 1'b1, download: 1'b0, normal: 1'b1,
               reserved: 1'b0, log_en: 1'b1, in_rise: 1'b1, out_rise: 1'b1};
    else
      s_q <= s_d;
  end

  assign raw             = s_q.raw;
  assign flash_1v8       = s_q.flash_1v8;
  assign download_boot   = s_q.download;
  assign normal_boot     = s_q.normal;
  assign boot_reserved   = s_q.reserved;
  assign log_enable      = s_q.log_en;
  assign sdio_in_rising  = s_q.in_rise;
  assign sdio_out_rising = s_q.out_rise;

endmodule // rbss_strap_capture
`default_nettype wire

// file: logic/rbss_radio_switch.sv
// Break-before-make owner switch of the shared radio path
`timescale 1ns/10ps
`default_nettype none
module rbss_radio_switch
  import rbss_pkg::*;
#(
  parameter logic [RADIO_CNT_W-1:0] GAP_CYC = RADIO_CNT_W'(RADIO_GAP_CYC)
)
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       hold,
  input  wire logic [1:0] req,
  output logic            wifi_en,
  output logic            bt_en
);

  typedef struct packed {
    rbss_radio_type         owner;
    logic [RADIO_CNT_W-1:0] gap;
    logic                   wifi;
    logic                   bt;
  } rbss_rsw_type;

  rbss_rsw_type   r_q;
  rbss_rsw_type   r_d;
  rbss_radio_type target;

  always_comb
  begin
    r_d    = r_q;
    target = RADIO_NONE;
    if (!hold && (req == RADIO_WIFI || req == RADIO_BT))
      target = rbss_radio_type'(req);
    // Owner is always dropped and a gap waited before the other takes over
    if (r_q.owner != target)
    begin
      if (r_q.owner != RADIO_NONE)
      begin
        r_d.owner = RADIO_NONE;
        r_d.gap   = GAP_CYC;
      end
      else if (r_q.gap != '0)
        r_d.gap = r_q.gap - 1'b1;
      else
        r_d.owner = target;
    end
    r_d.wifi = (r_d.owner == RADIO_WIFI);
    r_d.bt   = (r_d.owner == RADIO_BT);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      r_q <= '{owner: RADIO_NONE, gap: '0, wifi: 1'b0, bt: 1'b0};
    else
      r_q <= r_d;
  end

  assign wifi_en = r_q.wifi;
  assign bt_en   = r_q.bt;

endmodule // rbss_radio_switch
`default_nettype wire

// file: logic/rbss_top.sv
// Reset sequencing, boot strap capture, slow clock watch and Wishbone registers
//
// How it works
// - External reset pin low forces full core reset and reboot.
// - The reset pin has an internal pull-up, so open pin means run.
// - While reset pin is low the core sits in lowest power.
// - Every strap pin has an internal pull giving normal defaults when open.
// - Flash supply strap: 0 means 3.3V, 1 (default, pull-up) means 1.8V.
// - Boot mode straps reading 00 select download boot.
// - Boot mode 10 or 11 select normal flash boot; pulls give 10.
// - Log strap 1 (default) lets boot log toggle serial tx; 0 silences it.
// - SDIO timing 00 falling in/out; 01 falling in, rising out.
// - SDIO timing 10 rising in, falling out; 11 (default) rising in/out.
// - Shared radio path goes to Wi-Fi or Bluetooth, never both.
`timescale 1ns/10ps
`default_nettype none
module rbss_top
  import rbss_pkg::*;
#(
  parameter logic [SLOW_CNT_W-1:0]  SLOW_TIMEOUT = SLOW_CNT_W'(SLOW_TIMEOUT_CYC),
  parameter logic [RADIO_CNT_W-1:0] RADIO_GAP    = RADIO_CNT_W'(RADIO_GAP_CYC)
)
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               ext_reset_n,
  input  wire logic [STRAP_W-1:0] strap_pins,
  input  wire logic               slow_clock_in,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [DAT_W-1:0]   wb_dat_i,
  output logic      [DAT_W-1:0]   wb_dat_o,
  output logic                    wb_ack_o,
  output logic                    reset_pullup_en,
  output logic      [STRAP_W-1:0] strap_pullup_en,
  output logic      [STRAP_W-1:0] strap_pulldown_en,
  output logic                    core_reset,
  output logic                    low_power,
  output logic                    slow_clock_ok,
  output logic                    flash_1v8_sel,
  output logic                    download_boot,
  output logic                    normal_boot,
  output logic                    boot_reserved,
  output logic                    log_enable,
  output logic                    sdio_in_rising,
  output logic                    sdio_out_rising,
  output logic                    wifi_rf_en,
  output logic                    bt_rf_en
);

  typedef struct packed {
    rbss_phase_type          phase;
    logic                    core_rst;
    logic                    low_power;
    logic                    pu_rst;
    logic [STRAP_W-1:0]      pu_straps;
    logic [STRAP_W-1:0]      pd_straps;
    logic [1:0]              radio_req;
    logic                    lp_req;
    logic                    slow_prev;
    logic [SLOW_CNT_W-1:0]   slow_cnt;
    logic                    slow_ok;
    logic                    ack;
    logic [DAT_W-1:0]        dat;
  } rbss_top_type;

  rbss_top_type       t_q;
  rbss_top_type       t_d;

  logic               capture;
  logic               bus_req;
  logic [DAT_W-1:0]   status_word;
  logic [DAT_W-1:0]   control_word;
  logic [DAT_W-1:0]   straps_word;
  logic [STRAP_W-1:0] strap_raw;

  // Leaving hold for one sample cycle is the only capture moment
  assign capture = (t_q.phase == PH_SAMPLE);

  rbss_strap_capture u_straps
  (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .capture         (capture),
    .strap_pins      (strap_pins),
    .raw             (strap_raw),
    .flash_1v8       (flash_1v8_sel),
    .download_boot   (download_boot),
    .normal_boot     (normal_boot),
    .boot_reserved   (boot_reserved),
    .log_enable      (log_enable),
    .sdio_in_rising  (sdio_in_rising),
    .sdio_out_rising (sdio_out_rising)
  );

  rbss_radio_switch #(
    .GAP_CYC (RADIO_GAP)
  ) u_radio
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .hold    (t_q.core_rst),
    .req     (t_q.radio_req),
    .wifi_en (wifi_rf_en),
    .bt_en   (bt_rf_en)
  );

  assign bus_req = wb_cyc_i && wb_stb_i && !t_q.ack;

  // Register map, byte offsets:
  // Offset 0x0: status, read only, bit positions as named in the package
  // Offset 0x4: control, lane 0, [1:0] radio request (01 wifi, 10 bt), bit 2 low power
  // Offset 0x8: straps, read only, raw pin levels latched at boot

  always_comb
  begin
    status_word                   = '0;
    status_word[ST_FLASH_1V8]     = flash_1v8_sel;
    status_word[ST_DOWNLOAD]      = download_boot;
    status_word[ST_RESERVED]      = boot_reserved;
    status_word[ST_LOG]           = log_enable;
    status_word[ST_SDIO_IN_RISE]  = sdio_in_rising;
    status_word[ST_SDIO_OUT_RISE] = sdio_out_rising;
    status_word[ST_SLOW_OK]       = t_q.slow_ok;
    status_word[ST_WIFI]          = wifi_rf_en;
    status_word[ST_BT]            = bt_rf_en;
    status_word[ST_LOW_POWER]     = t_q.low_power;
    status_word[ST_NORMAL]        = normal_boot;
  end

  always_comb
  begin
    control_word                                 = '0;
    control_word[CTL_RADIO_LSB +: 2]             = t_q.radio_req;
    control_word[CTL_LP_BIT]                     = t_q.lp_req;
  end

  // Straps word shows the pins as latched, not as they read now
  always_comb
  begin
    straps_word                                  = '0;
    straps_word[STRAP_W-1:0]                     = strap_raw;
  end

  always_comb
  begin
    t_d = t_q;

    // Pull enables stay on through every reset so open pins read defaults
    t_d.pu_rst    = 1'b1;
    t_d.pu_straps = STRAP_PU;
    t_d.pd_straps = STRAP_PD;

    // Only a low level matters; a board that never drives high is assumed
    unique case (t_q.phase)
      PH_HOLD:
      begin
        if (ext_reset_n)
        begin
          t_d.phase = PH_SAMPLE;
        end
      end
      PH_SAMPLE:
      begin
        // A pin that drops again during sampling restarts the wait
        if (ext_reset_n)
        begin
          t_d.phase = PH_RUN;
        end
        else
        begin
          t_d.phase = PH_HOLD;
        end
      end
      PH_RUN:
      begin
        if (!ext_reset_n)
        begin
          t_d.phase = PH_HOLD;
        end
      end
      default:
      begin
        t_d.phase = PH_HOLD;
      end
    endcase

    t_d.core_rst = (t_d.phase != PH_RUN);

    // Slow clock watch: any edge within the window marks it present
    t_d.slow_prev = slow_clock_in;
    if (slow_clock_in != t_q.slow_prev)
    begin
      t_d.slow_cnt = '0;
      t_d.slow_ok  = 1'b1;
    end
    else if (t_q.slow_cnt >= SLOW_TIMEOUT)
    begin
      // Count parks at the limit so a stopped clock stays flagged
      t_d.slow_ok = 1'b0;
    end
    else
    begin
      t_d.slow_cnt = t_q.slow_cnt + 1'b1;
    end

    // Register bus, one wait state, unmapped reads give zero
    // Ack is registered and masks the request, so a held strobe cannot write twice
    t_d.ack = bus_req;
    t_d.dat = '0;
    if (bus_req && !wb_we_i)
    begin
      unique case (wb_adr_i)
        ADR_STATUS:
        begin
          t_d.dat = status_word;
        end
        ADR_CONTROL:
        begin
          t_d.dat = control_word;
        end
        ADR_STRAPS:
        begin
          t_d.dat = straps_word;
        end
        default:
        begin
          t_d.dat = '0;
        end
      endcase
    end
    if (bus_req && wb_we_i)
    begin
      unique case (wb_adr_i)
        ADR_CONTROL:
        begin
          // Only byte lane 0 holds control bits
          if (wb_sel_i[0])
          begin
            t_d.radio_req = wb_dat_i[CTL_RADIO_LSB +: 2];
            t_d.lp_req    = wb_dat_i[CTL_LP_BIT];
          end
        end
        default:
        begin
          // Read-only and unmapped words take the write without effect
        end
      endcase
    end

    // Full reset clears software control too
    if (t_d.core_rst)
    begin
      t_d.radio_req = RADIO_NONE;
      t_d.lp_req    = 1'b0;
    end

    // Low power needs the board clock; held reset always means lowest power
    if (t_d.phase == PH_HOLD)
    begin
      t_d.low_power = 1'b1;
    end
    else
    begin
      t_d.low_power = t_d.lp_req && t_d.slow_ok && !t_d.core_rst;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      t_q           <= '0;
      t_q.phase     <= PH_HOLD;
      t_q.core_rst  <= 1'b1;
      t_q.low_power <= 1'b1;
      t_q.pu_rst    <= 1'b1;
      t_q.pu_straps <= STRAP_PU;
      t_q.pd_straps <= STRAP_PD;
      t_q.radio_req <= RADIO_NONE;
    end
    else
    begin
      t_q <= t_d;
    end
  end

  assign wb_dat_o          = t_q.dat;
  assign wb_ack_o          = t_q.ack;
  assign reset_pullup_en   = t_q.pu_rst;
  assign strap_pullup_en   = t_q.pu_straps;
  assign strap_pulldown_en = t_q.pd_straps;
  assign core_reset        = t_q.core_rst;
  assign low_power         = t_q.low_power;
  assign slow_clock_ok     = t_q.slow_ok;

endmodule // rbss_top
`default_nettype wire

// file: test/rbss_checker.sv
// Port-level checker for the reset and boot strap select block
`timescale 1ns/10ps
`default_nettype none
module rbss_checker
  import rbss_pkg::*;
#(
  parameter logic [SLOW_CNT_W-1:0]  SLOW_TIMEOUT = 12'h014,
  parameter logic [RADIO_CNT_W-1:0] RADIO_GAP    = 8'h02
)
(
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic               ext_reset_n,
  input wire logic               reset_pullup_en,
  input wire logic [STRAP_W-1:0] strap_pullup_en,
  input wire logic [STRAP_W-1:0] strap_pulldown_en,
  input wire logic               core_reset,
  input wire logic               low_power,
  input wire logic               slow_clock_ok,
  input wire logic               flash_1v8_sel,
  input wire logic               download_boot,
  input wire logic               normal_boot,
  input wire logic               boot_reserved,
  input wire logic               log_enable,
  input wire logic               sdio_in_rising,
  input wire logic               sdio_out_rising,
  input wire logic               wifi_rf_en,
  input wire logic               bt_rf_en
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_pin_reboot: assert property (!ext_reset_n |=> core_reset && low_power)
    else $error("pin reset did not hold core in low power reset");
  a_reset_pullup: assert property (reset_pullup_en == 1'b1)
    else $error("reset pin pull-up off");
  a_strap_pulls: assert property (strap_pullup_en == STRAP_PU
    && strap_pulldown_en == STRAP_PD)
    else $error("strap pulls wrong");
  a_boot_onehot: assert property ($onehot({download_boot, normal_boot, boot_reserved}))
    else $error("boot mode decode not one-hot");
  a_log_sdio_pin: assert property (log_enable == sdio_in_rising)
    else $error("shared log strap decoded twice differently");
  a_lp_needs_slow: assert property (low_power && !core_reset |-> slow_clock_ok)
    else $error("low power without slow clock");
  a_radio_excl: assert property (!(wifi_rf_en && bt_rf_en))
    else $error("both radios own the path");
  a_radio_drop: assert property (!ext_reset_n |-> ##2 (!wifi_rf_en && !bt_rf_en))
    else $error("radio kept through pin reset");
  a_strap_hold: assert property (!core_reset && !$past(core_reset) |->
    $stable({flash_1v8_sel, download_boot, normal_boot, boot_reserved, log_enable,
             sdio_in_rising, sdio_out_rising}))
    else $error("strap decode changed while running");

  c_pin_reset: cover property (!ext_reset_n);
  c_wifi: cover property (wifi_rf_en);
  c_bt: cover property (bt_rf_en);
  c_low_power: cover property (low_power && !core_reset);
endmodule // rbss_checker

bind rbss_top rbss_checker #(.SLOW_TIMEOUT(SLOW_TIMEOUT), .RADIO_GAP(RADIO_GAP)) u_check (
  .clk, .sys_rst, .ext_reset_n, .reset_pullup_en, .strap_pullup_en, .strap_pulldown_en,
  .core_reset, .low_power, .slow_clock_ok, .flash_1v8_sel, .download_boot, .normal_boot,
  .boot_reserved, .log_enable, .sdio_in_rising, .sdio_out_rising, .wifi_rf_en, .bt_rf_en
);
`default_nettype wire

// file: test/rbss_board_model.sv
// Board model: strap resistors, reset switch and slow clock source
`timescale 1ns/10ps
`default_nettype none
module rbss_board_model
  import rbss_pkg::*;
(
  input  wire logic               clk,
  input  wire logic [STRAP_W-1:0] drive_en,
  input  wire logic [STRAP_W-1:0] drive_val,
  input  wire logic [STRAP_W-1:0] pullup_en,
  input  wire logic [STRAP_W-1:0] pulldown_en,
  input  wire logic               press,
  input  wire logic               pullup_rst,
  input  wire logic               slow_run,
  output logic      [STRAP_W-1:0] strap_pins,
  output logic                    ext_reset_n,
  output logic                    slow_clock_in
);
  logic       toggle_q = 1'b0;
  logic [2:0] div_q    = 3'h0;
  logic       slow_q   = 1'b0;

  // Unpulled open lines wander so a missing pull cannot pass unseen
  always @(posedge clk)
    toggle_q <= ~toggle_q;

  assign strap_pins = (drive_en & drive_val) | (~drive_en & pullup_en)
                    | (~drive_en & ~pullup_en & ~pulldown_en & {STRAP_W{toggle_q}});
  // Switch only pulls low; high comes from the pull-up alone
  assign ext_reset_n = press ? 1'b0 : (pullup_rst ? 1'b1 : toggle_q);

  // Scaled-up slow clock, still while not needed
  always @(posedge clk)
    if (slow_run)
    begin
      div_q <= div_q + 3'h1;
      if (div_q == 3'h3)
        slow_q <= ~slow_q;
    end
  assign slow_clock_in = slow_q;
endmodule // rbss_board_model
`default_nettype wire

// file: test/rbss_top_tb.sv
// Self-checking bench for the reset and boot strap select block
`timescale 1ns/10ps
`default_nettype none
module rbss_top_tb;
  import rbss_pkg::*;
  logic               clk = 1'b0;
  logic               sys_rst = 1'b1;
  logic               wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [ADR_W-1:0]   wb_adr_i = '0;
  logic [3:0]         wb_sel_i = '0;
  logic [DAT_W-1:0]   wb_dat_i = '0, wb_dat_o;
  logic               wb_ack_o, reset_pullup_en, ext_reset_n, slow_clock_in;
  logic [STRAP_W-1:0] strap_pins, strap_pullup_en, strap_pulldown_en, cur;
  logic [STRAP_W-1:0] drv_en = '0, drv_val = '0;
  logic               press = 1'b0, slow_run = 1'b0;
  logic [31:0]        rng = 32'h70f3;
  logic [DAT_W-1:0]   exp_q[$];
  int                 fail_count = 0, check_count = 0;

  always #12.5 clk = ~clk;

  rbss_top #(.SLOW_TIMEOUT(12'h014), .RADIO_GAP(8'h02)) DUT (
    .clk, .sys_rst, .ext_reset_n, .strap_pins, .slow_clock_in, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .reset_pullup_en,
    .strap_pullup_en, .strap_pulldown_en, .core_reset(), .low_power(), .slow_clock_ok(),
    .flash_1v8_sel(), .download_boot(), .normal_boot(), .boot_reserved(), .log_enable(),
    .sdio_in_rising(), .sdio_out_rising(), .wifi_rf_en(), .bt_rf_en()
  );

  rbss_board_model u_board (
    .clk, .drive_en(drv_en), .drive_val(drv_val), .pullup_en(strap_pullup_en),
    .pulldown_en(strap_pulldown_en), .press, .pullup_rst(reset_pullup_en), .slow_run,
    .strap_pins, .ext_reset_n, .slow_clock_in
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction

  // Board never presents the reserved boot code
  function automatic logic [STRAP_W-1:0] legal(input logic [STRAP_W-1:0] v);
    logic [STRAP_W-1:0] r;
    r = v;
    if ({v[SP_BOOT_HI], v[SP_BOOT_LO]} == BOOT_RESERVED)
      r[SP_BOOT_HI] = 1'b1;
    return r;
  endfunction

  // Flags f are {low_power, slow_ok, bt, wifi}
  function automatic logic [DAT_W-1:0] st_exp(input logic [STRAP_W-1:0] v, input logic [3:0] f);
    logic [DAT_W-1:0] r;
    r = '0;
    r[ST_FLASH_1V8] = v[SP_FLASH];
    r[ST_DOWNLOAD] = {v[SP_BOOT_HI], v[SP_BOOT_LO]} == BOOT_DOWNLOAD;
    r[ST_RESERVED] = {v[SP_BOOT_HI], v[SP_BOOT_LO]} == BOOT_RESERVED;
    r[ST_NORMAL] = v[SP_BOOT_HI];
    r[ST_LOG] = v[SP_LOG];
    r[ST_SDIO_IN_RISE] = v[SP_LOG];
    r[ST_SDIO_OUT_RISE] = v[SP_SDIO_LO];
    {r[ST_LOW_POWER], r[ST_SLOW_OK], r[ST_BT], r[ST_WIFI]} = f;
    return r;
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [DAT_W-1:0] seen, input logic [DAT_W-1:0] expd);
    check_count++;
    if (seen !== expd)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, seen, expd);
      fail_count++;
    end
  endtask

  // Entered just after an edge; returns one edge after release
  task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d,
                     input logic [3:0] s);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1)
    begin
      fail_count++;
      test_done;
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, '0, 4'hf);
  endtask

  task automatic ctl(input logic [DAT_W-1:0] d, input logic [3:0] s);
    bus(1'b1, ADR_CONTROL, d, s);
    repeat (8) @(posedge clk);
  endtask

  // Straps held through release, then noise the design must ignore
  task automatic pin_reset(input logic [STRAP_W-1:0] v);
    drv_en <= '1;
    drv_val <= v;
    press <= 1'b1;
    repeat (3) @(posedge clk);
    press <= 1'b0;
    repeat (6) @(posedge clk);
    rng = xs(rng);
    drv_val <= legal(rng[STRAP_W-1:0]);
    @(posedge clk);
  endtask

  always @(posedge clk)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
    begin
      if (exp_q.size() == 0)
        check('0, '1);
      else
        check(wb_dat_o, exp_q.pop_front());
    end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done;
  end

  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd(ADR_STRAPS, DAT_W'(STRAP_PU));
    rd(ADR_STATUS, st_exp(STRAP_PU, 4'h0));
    bus(1'b1, ADR_STATUS, '1, 4'hf);
    rd(ADR_STATUS, st_exp(STRAP_PU, 4'h0));
    rd(4'hc, '0);
    for (int i = 0; i < 32; i++)
    begin
      cur = legal(STRAP_W'(i));
      pin_reset(cur);
      rd(ADR_STRAPS, DAT_W'(cur));
      rd(ADR_STATUS, st_exp(cur, 4'h0));
    end
    cur = STRAP_PU;
    pin_reset(cur);
    ctl(32'h1, 4'h1);
    rd(ADR_STATUS, st_exp(cur, 4'h1));
    ctl(32'h2, 4'h1);
    rd(ADR_STATUS, st_exp(cur, 4'h2));
    ctl(32'h1, 4'he);
    rd(ADR_STATUS, st_exp(cur, 4'h2));
    ctl(32'h3, 4'h1);
    rd(ADR_STATUS, st_exp(cur, 4'h0));
    slow_run <= 1'b1;
    repeat (8) @(posedge clk);
    ctl(32'h4, 4'h1);
    rd(ADR_STATUS, st_exp(cur, 4'hc));
    slow_run <= 1'b0;
    repeat (40) @(posedge clk);
    rd(ADR_STATUS, st_exp(cur, 4'h0));
    rd(ADR_CONTROL, 32'h4);
    ctl(32'h1, 4'h1);
    rd(ADR_STATUS, st_exp(cur, 4'h1));
    pin_reset(cur);
    rd(ADR_CONTROL, '0);
    rd(ADR_STATUS, st_exp(cur, 4'h0));
    test_done;
  end
endmodule // rbss_top_tb
`default_nettype wire
